/* logic/nvm_prog_pkg.sv */
// Constants and carrier types for the parallel programming port.
// Assumes a single 250 MHz core clock; all pins sampled synchronously.
package nvm_prog_pkg;

  // Core clock period in ps
  localparam int unsigned CLK_PERIOD_PS = 4000;

  // Timing figures as printed
  localparam int unsigned BUSY_LOW_MAX_US  = 1;
  localparam int unsigned WRITE_MIN_US     = 3700;
  localparam int unsigned WRITE_MAX_US     = 4500;
  localparam int unsigned ERASE_MIN_US     = 7500;
  localparam int unsigned ERASE_MAX_US     = 9000;
  // Target time chosen inside each window, in us
  localparam int unsigned WRITE_TARGET_US  = 4000;
  localparam int unsigned ERASE_TARGET_US  = 8000;

  // Derived cycle counts
  localparam longint unsigned WRITE_CYCLES =
    (longint'(WRITE_TARGET_US) * 1000000) / CLK_PERIOD_PS;
  localparam longint unsigned ERASE_CYCLES =
    (longint'(ERASE_TARGET_US) * 1000000) / CLK_PERIOD_PS;
  localparam longint unsigned BUSY_LOW_MAX_CYCLES =
    (longint'(BUSY_LOW_MAX_US) * 1000000) / CLK_PERIOD_PS;

  localparam int unsigned TIMER_W = 24;

  // Command bytes
  localparam logic [7:0] CMD_NOP       = 8'h00;
  localparam logic [7:0] CMD_ERASE     = 8'h80;
  localparam logic [7:0] CMD_WR_FUSE   = 8'h40;
  localparam logic [7:0] CMD_WR_LOCK   = 8'h20;
  localparam logic [7:0] CMD_WR_FLASH  = 8'h10;
  localparam logic [7:0] CMD_WR_EEPROM = 8'h11;
  localparam logic [7:0] CMD_RD_SIG    = 8'h08;
  localparam logic [7:0] CMD_RD_FUSE   = 8'h04;
  localparam logic [7:0] CMD_RD_FLASH  = 8'h02;
  localparam logic [7:0] CMD_RD_EEPROM = 8'h03;

  // Load-select codes
  localparam logic [1:0] LOAD_ADDR = 2'h0;
  localparam logic [1:0] LOAD_DATA = 2'h1;
  localparam logic [1:0] LOAD_CMD  = 2'h2;

  // Byte-select codes {hi, lo}
  localparam logic [1:0] BSEL_00 = 2'h0;
  localparam logic [1:0] BSEL_01 = 2'h1;
  localparam logic [1:0] BSEL_10 = 2'h2;
  localparam logic [1:0] BSEL_11 = 2'h3;

  // Reset values of nonvolatile bytes (all unprogrammed)
  localparam logic [7:0] FUSE_LO_RST  = 8'hff;
  localparam logic [7:0] FUSE_HI_RST  = 8'hff;
  localparam logic [7:0] FUSE_EXT_RST = 8'hff;
  localparam logic [7:0] LOCK_RST     = 8'hff;
  // Lock byte fields: general locks bits 1:0, boot locks bits 5:2
  localparam int unsigned LOCK_GEN_LSB  = 0;
  localparam logic [7:0]  LOCK_BOOT_MSK = 8'h3c;

  // Memory sizes
  localparam int unsigned FLASH_AW  = 10;
  localparam int unsigned EEPROM_AW = 8;
  localparam int unsigned EE_PAGE_AW = 3;

  // Pin bundle from the programmer
  typedef struct packed {
    logic       load_strobe;
    logic [1:0] load_select;   // {load_select_hi, load_select_lo}
    logic [1:0] byte_select;   // {byte_select_hi, byte_select_lo}
    logic       page_latch_strobe;
    logic       write_n;
    logic       out_enable_n;
    logic [7:0] data;
  } prog_pins_t;

  // Identity bytes, values arbitrary
  typedef struct packed {
    logic [7:0] sig0;
    logic [7:0] sig1;
    logic [7:0] sig2;
    logic [7:0] calib;
  } ident_t;

  typedef enum logic [1:0] {ST_IDLE, ST_BUSY} busy_state_t;

endpackage

/* logic/nvm_busy_timer.sv */
// Self-timed busy interval for a nonvolatile write or erase.
// Assumes start is a one-cycle pulse taken only while idle.
`timescale 1ns/100ps
module nvm_busy_timer
  import nvm_prog_pkg::*;
#(
  parameter logic [TIMER_W-1:0] WRITE_LEN = TIMER_W'(WRITE_CYCLES),
  parameter logic [TIMER_W-1:0] ERASE_LEN = TIMER_W'(ERASE_CYCLES)
) (
  input  wire logic i_core_clk,
  input  wire logic i_rst_b,
  input  wire logic i_start,
  input  wire logic i_erase,
  output logic      o_busy,
  output logic      o_done
);

  typedef struct packed {
    busy_state_t        st;
    logic [TIMER_W-1:0] cnt;
    logic               done;
  } timer_st_t;

  timer_st_t s_q;
  timer_st_t s_d;

  // Count down the chosen interval; done pulses at the end
  always_comb begin
    s_d      = s_q;
    s_d.done = 1'b0;
    case (s_q.st)
      ST_IDLE: begin
        if (i_start) begin
          s_d.st  = ST_BUSY;
          s_d.cnt = i_erase ? ERASE_LEN : WRITE_LEN;
        end
      end
      ST_BUSY: begin
        if (s_q.cnt <= TIMER_W'(1)) begin
          s_d.st   = ST_IDLE;
          s_d.done = 1'b1;
        end else begin
          s_d.cnt = s_q.cnt - TIMER_W'(1);
        end
      end
      default: s_d.st = ST_IDLE;
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      s_q <= '{st: ST_IDLE, cnt: '0, done: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign o_busy = (s_q.st == ST_BUSY);
  assign o_done = s_q.done;

endmodule

/* logic/nvm_prog_port.sv */
// Device side of the parallel high-voltage programming port.
// Assumes programming mode has been entered and all pins are synchronous.
`timescale 1ns/100ps
module nvm_prog_port
  import nvm_prog_pkg::*;
#(
  parameter logic [TIMER_W-1:0] WRITE_LEN = TIMER_W'(WRITE_CYCLES),
  parameter logic [TIMER_W-1:0] ERASE_LEN = TIMER_W'(ERASE_CYCLES),
  parameter ident_t             IDENT     = '{sig0: 8'h5a, sig1: 8'h01,
                                              sig2: 8'h02, calib: 8'h80} // Arbitrary
) (
  input  wire logic       i_core_clk,
  input  wire logic       i_rst_b,
  input  wire prog_pins_t i_pins,
  output logic [7:0]      o_data,
  output logic            o_data_oe,
  output logic            o_ready_busy_flag,
  output logic [7:0]      o_fuse_lo,
  output logic [7:0]      o_fuse_hi,
  output logic [7:0]      o_fuse_ext,
  output logic [7:0]      o_lock_bits
);

  ////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    logic       strobe_prev;
    logic       page_prev;
    logic       write_prev;
    logic [7:0] cmd;
    logic [7:0] addr_lo;
    logic [7:0] addr_hi;
    logic [7:0] addr_ext;
    logic [7:0] data_lo;
    logic [7:0] data_hi;
    logic       wr_armed;     // Internal write signals of a page write
    logic       pend_erase;
    logic [7:0] fuse_lo;
    logic [7:0] fuse_hi;
    logic [7:0] fuse_ext;
    logic [7:0] lock;
    logic [7:0] rd_byte;
    logic       rd_en;
  } port_st_t;

  port_st_t s_q;
  port_st_t s_d;

  // Memory arrays; erased state is all ones
  logic [15:0] flash_mem   [0:(1<<FLASH_AW)-1];
  logic [15:0] flash_buf   [0:(1<<FLASH_AW)-1];
  logic [7:0]  eeprom_mem  [0:(1<<EEPROM_AW)-1];
  logic [7:0]  ee_buf      [0:(1<<EE_PAGE_AW)-1];

  logic busy;
  logic busy_any;
  logic done;
  logic strobe_rise;
  logic page_rise;
  logic write_fall;
  logic start;
  logic is_write_cmd;

  assign strobe_rise = i_pins.load_strobe & ~s_q.strobe_prev;
  assign page_rise   = i_pins.page_latch_strobe & ~s_q.page_prev;
  assign write_fall  = ~i_pins.write_n & s_q.write_prev;

  assign is_write_cmd = (s_q.cmd == CMD_WR_FLASH) || (s_q.cmd == CMD_WR_EEPROM) ||
                        (s_q.cmd == CMD_WR_FUSE)  || (s_q.cmd == CMD_WR_LOCK) ||
                        (s_q.cmd == CMD_ERASE);
  // Erase stays busy one cycle past the timer so the lock reset shows with ready
  assign busy_any = busy | s_q.pend_erase;
  // Writes while busy are ignored; the programmer must poll the flag
  assign start = write_fall & ~busy_any & is_write_cmd;

  ////////////////////////////////////////////////////////////////////////////
  // Self-timed write interval

  nvm_busy_timer #(
    .WRITE_LEN (WRITE_LEN),
    .ERASE_LEN (ERASE_LEN)
  ) u_timer (
    .i_core_clk (i_core_clk),
    .i_rst_b    (i_rst_b),
    .i_start    (start),
    .i_erase    (s_q.cmd == CMD_ERASE),
    .o_busy     (busy),
    .o_done     (done)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Pin decode, retained command/address, fuse and lock updates

  always_comb begin
    logic [7:0] new_lock;
    new_lock      = s_q.lock;
    s_d             = s_q;
    s_d.strobe_prev = i_pins.load_strobe;
    s_d.page_prev   = i_pins.page_latch_strobe;
    s_d.write_prev  = i_pins.write_n;

    // Loads on the strobe pin; command and address persist until reloaded
    if (strobe_rise && !busy_any) begin
      case (i_pins.load_select)
        LOAD_ADDR: begin
          case (i_pins.byte_select)
            BSEL_00: s_d.addr_lo  = i_pins.data;
            BSEL_01: s_d.addr_hi  = i_pins.data;
            BSEL_10: s_d.addr_ext = i_pins.data;
            default: ;
          endcase
        end
        LOAD_DATA: begin
          if (i_pins.byte_select[0]) s_d.data_hi = i_pins.data;
          else                       s_d.data_lo = i_pins.data;
        end
        LOAD_CMD: begin
          s_d.cmd      = i_pins.data;
          s_d.wr_armed = (i_pins.data == CMD_WR_FLASH) ||
                         (i_pins.data == CMD_WR_EEPROM);
          if (i_pins.data == CMD_NOP) s_d.wr_armed = 1'b0;
        end
        default: ;
      endcase
    end

    // Fuse and lock writes take effect at the start of the interval
    if (start) begin
      if (s_q.cmd == CMD_WR_FUSE) begin
        case (i_pins.byte_select)
          BSEL_00: s_d.fuse_lo  = s_q.data_lo;
          BSEL_01: s_d.fuse_hi  = s_q.data_lo;
          BSEL_10: s_d.fuse_ext = s_q.data_lo;
          default: ;
        endcase
      end
      if (s_q.cmd == CMD_WR_LOCK) begin
        // Only clearing bits is possible; ones never unprogram a lock
        new_lock = s_q.lock & s_q.data_lo;
        if (s_q.lock[LOCK_GEN_LSB +: 2] == 2'b00) begin
          new_lock = (new_lock & ~LOCK_BOOT_MSK) | (s_q.lock & LOCK_BOOT_MSK);
        end
        s_d.lock = new_lock;
      end
      s_d.pend_erase = (s_q.cmd == CMD_ERASE);
    end

    // Chip erase resets locks only once memory erase completes
    if (done && s_q.pend_erase) begin
      s_d.lock       = LOCK_RST;
      s_d.pend_erase = 1'b0;
    end

    // Read mux, registered so the data bus comes from a flip-flop
    s_d.rd_en   = ~i_pins.out_enable_n &
                  ((s_q.cmd == CMD_RD_FLASH) || (s_q.cmd == CMD_RD_EEPROM) ||
                   (s_q.cmd == CMD_RD_FUSE)  || (s_q.cmd == CMD_RD_SIG));
    s_d.rd_byte = 8'hff;
    case (s_q.cmd)
      CMD_RD_FLASH: begin
        s_d.rd_byte = i_pins.byte_select[0] ?
          flash_mem[{s_q.addr_hi[1:0], s_q.addr_lo}][15:8] :
          flash_mem[{s_q.addr_hi[1:0], s_q.addr_lo}][7:0];
      end
      CMD_RD_EEPROM: begin
        if (!i_pins.byte_select[0]) s_d.rd_byte = eeprom_mem[s_q.addr_lo];
      end
      CMD_RD_FUSE: begin
        case (i_pins.byte_select)
          BSEL_00: s_d.rd_byte = s_q.fuse_lo;
          BSEL_11: s_d.rd_byte = s_q.fuse_hi;
          BSEL_10: s_d.rd_byte = s_q.fuse_ext;
          default: s_d.rd_byte = s_q.lock;
        endcase
      end
      CMD_RD_SIG: begin
        if (i_pins.byte_select[0]) begin
          if (s_q.addr_lo == 8'h00) s_d.rd_byte = IDENT.calib;
        end else begin
          case (s_q.addr_lo)
            8'h00:   s_d.rd_byte = IDENT.sig0;
            8'h01:   s_d.rd_byte = IDENT.sig1;
            8'h02:   s_d.rd_byte = IDENT.sig2;
            default: s_d.rd_byte = 8'hff;
          endcase
        end
      end
      default: ;
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      s_q <= '{strobe_prev: 1'b0, page_prev: 1'b0, write_prev: 1'b1,
               cmd: CMD_NOP, addr_lo: 8'h00, addr_hi: 8'h00, addr_ext: 8'h00,
               data_lo: 8'hff, data_hi: 8'hff, wr_armed: 1'b0, pend_erase: 1'b0,
               fuse_lo: FUSE_LO_RST, fuse_hi: FUSE_HI_RST, fuse_ext: FUSE_EXT_RST,
               lock: LOCK_RST, rd_byte: 8'hff, rd_en: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Page buffers and arrays; no reset on memories, erase handled explicitly

  always_ff @(posedge i_core_clk) begin
    // Page latch copies loaded data into the matching page buffer
    if (page_rise && !busy_any) begin
      if (s_q.cmd == CMD_WR_EEPROM) begin
        ee_buf[s_q.addr_lo[EE_PAGE_AW-1:0]] <= s_q.data_lo;
      end else begin
        flash_buf[{s_q.addr_hi[1:0], s_q.addr_lo}] <= {s_q.data_hi, s_q.data_lo};
      end
    end
    // Page commits happen when the write interval starts
    if (start && s_q.wr_armed && i_pins.byte_select == BSEL_00) begin
      if (s_q.cmd == CMD_WR_EEPROM) begin
        for (int i = 0; i < (1 << EE_PAGE_AW); i++) begin
          eeprom_mem[{s_q.addr_lo[EEPROM_AW-1:EE_PAGE_AW], EE_PAGE_AW'(i)}] <=
            ee_buf[i];
        end
      end else begin
        flash_mem[{s_q.addr_hi[1:0], s_q.addr_lo}] <=
          flash_buf[{s_q.addr_hi[1:0], s_q.addr_lo}];
      end
    end
    if (start && s_q.cmd == CMD_ERASE) begin
      for (int i = 0; i < (1 << FLASH_AW); i++) flash_mem[i] <= 16'hffff;
      for (int i = 0; i < (1 << EEPROM_AW); i++) eeprom_mem[i] <= 8'hff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  // Busy drops the cycle after the strobe falls, far inside the 1 us bound
  assign o_ready_busy_flag = ~busy_any;
  assign o_data            = s_q.rd_byte;
  assign o_data_oe         = s_q.rd_en;
  assign o_fuse_lo         = s_q.fuse_lo;
  assign o_fuse_hi         = s_q.fuse_hi;
  assign o_fuse_ext        = s_q.fuse_ext;
  assign o_lock_bits       = s_q.lock;

endmodule

/* test/nvm_programmer.sv */
// Programmer model: drives the port pins and owns the shared data bus.
// Assumes the device drives the bus only while i_data_oe is high.
`timescale 1ns/100ps
module nvm_programmer
  import nvm_prog_pkg::*;
(
  input  wire logic       i_core_clk,
  input  wire logic [7:0] i_data,
  input  wire logic       i_data_oe,
  output prog_pins_t      o_pins
);
  localparam int PW = 38; // 150 ns widths and holds at 4 ns
  prog_pins_t pin_q = '{1'b0, 2'h3, 2'h0, 1'b0, 1'b1, 1'b1, 8'h00};

  // Resolved bus: device wins while it drives, else our byte
  always_comb begin
    o_pins = pin_q;
    if (i_data_oe) begin
      o_pins.data = i_data;
    end
  end

  task automatic hold();
    repeat (PW) @(negedge i_core_clk);
  endtask

  // Strobe pulse with selects and data held around it
  task automatic load(input logic [1:0] sel, input logic [1:0] bs, input logic [7:0] v);
    pin_q.load_select = sel;
    pin_q.byte_select = bs;
    pin_q.data        = v;
    hold();
    pin_q.load_strobe = 1'b1;
    hold();
    pin_q.load_strobe = 1'b0;
    hold();
  endtask

  task automatic latch();
    pin_q.page_latch_strobe = 1'b1;
    hold();
    pin_q.page_latch_strobe = 1'b0;
    hold();
  endtask

  // Selects go back to 00 once the pulse is over
  task automatic write(input logic [1:0] bs);
    pin_q.byte_select = bs;
    hold();
    pin_q.write_n = 1'b0;
    hold();
    pin_q.write_n = 1'b1;
    pin_q.byte_select = BSEL_00;
    hold();
  endtask

  // Released bus shows the inverse of our last byte
  task automatic read(input logic [1:0] bs, output logic [7:0] v, output logic oe);
    pin_q.byte_select  = bs;
    pin_q.out_enable_n = 1'b0;
    pin_q.data         = ~pin_q.data;
    hold();
    v  = o_pins.data;
    oe = i_data_oe;
    pin_q.out_enable_n = 1'b1;
    hold();
  endtask
endmodule

/* test/nvm_prog_port_assertions.sv */
// Pin-level checker for the programming port.
// Assumes it is bound onto nvm_prog_port and sees only its ports.
`timescale 1ns/100ps
module nvm_prog_port_assertions
  import nvm_prog_pkg::*;
#(
  parameter logic [TIMER_W-1:0] WRITE_LEN = TIMER_W'(WRITE_CYCLES),
  parameter logic [TIMER_W-1:0] ERASE_LEN = TIMER_W'(ERASE_CYCLES),
  parameter ident_t             IDENT     = '0
) (
  input wire logic       i_core_clk,
  input wire logic       i_rst_b,
  input wire prog_pins_t i_pins,
  input wire logic [7:0] o_data,
  input wire logic       o_data_oe,
  input wire logic       o_ready_busy_flag,
  input wire logic [7:0] o_fuse_lo,
  input wire logic [7:0] o_fuse_hi,
  input wire logic [7:0] o_fuse_ext,
  input wire logic [7:0] o_lock_bits
);
  logic [7:0]  cmd_q, adr_q, dat_q;
  logic        stb_q, wn_q, ers_q, take, wr_go, rd_cmd, wr_cmd;
  logic [23:0] cnt_q;

  ////////////////////////////////////////////////////////////////////////
  // Shadow of loaded bytes; loads while busy are dropped like the device
  assign take   = i_pins.load_strobe && !stb_q && o_ready_busy_flag;
  assign wr_cmd = cmd_q inside {CMD_ERASE, CMD_WR_FUSE, CMD_WR_LOCK, CMD_WR_FLASH, CMD_WR_EEPROM};
  assign rd_cmd = cmd_q inside {CMD_RD_SIG, CMD_RD_FUSE, CMD_RD_FLASH, CMD_RD_EEPROM};
  assign wr_go  = !i_pins.write_n && wn_q && o_ready_busy_flag && wr_cmd;

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      {stb_q, wn_q, ers_q, cmd_q, adr_q, dat_q, cnt_q} <= {3'h2, 24'h0, 24'h0};
    end else begin
      stb_q <= i_pins.load_strobe;
      wn_q  <= i_pins.write_n;
      cnt_q <= o_ready_busy_flag ? 24'h0 : cnt_q + 24'h1; // Busy length
      if (take && i_pins.load_select == LOAD_CMD) cmd_q <= i_pins.data;
      // Only the low data byte feeds fuse and lock writes
      if (take && i_pins.load_select == LOAD_DATA && !i_pins.byte_select[0]) begin
        dat_q <= i_pins.data;
      end
      if (take && i_pins.load_select == LOAD_ADDR && i_pins.byte_select == BSEL_00) begin
        adr_q <= i_pins.data;
      end
      if (wr_go) ers_q <= (cmd_q == CMD_ERASE);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_b);

  busy_start_a: assert property (wr_go |=> !o_ready_busy_flag)
    else $error("busy flag did not fall after write strobe");
  write_len_a: assert property ($rose(o_ready_busy_flag) && !ers_q |->
    cnt_q >= WRITE_LEN - 24'h1 && cnt_q <= WRITE_LEN + 24'h1) else $error("write busy length");
  erase_len_a: assert property ($rose(o_ready_busy_flag) && ers_q |->
    cnt_q >= ERASE_LEN - 24'h1 && cnt_q <= ERASE_LEN + 24'h1) else $error("erase busy length");
  bus_drive_a: assert property (
    o_data_oe |-> $past(i_pins.out_enable_n) == 1'b0 && $past(rd_cmd))
    else $error("bus driven outside a read");
  bus_enable_a: assert property (!i_pins.out_enable_n && rd_cmd |=> o_data_oe)
    else $error("bus not driven during a read");
  fuse_hi_a: assert property (
    wr_go && cmd_q == CMD_WR_FUSE && i_pins.byte_select == BSEL_01 |=>
    o_fuse_hi == dat_q && $stable(o_fuse_lo)) else $error("high fuse write");
  fuse_ext_a: assert property (
    wr_go && cmd_q == CMD_WR_FUSE && i_pins.byte_select == BSEL_10 |=>
    o_fuse_ext == dat_q) else $error("extended fuse write");
  lock_write_a: assert property (wr_go && cmd_q == CMD_WR_LOCK |=> o_lock_bits ==
    ($past(o_lock_bits) & (dat_q |
      (($past(o_lock_bits) & 8'h03) == 8'h00 ? LOCK_BOOT_MSK : 8'h00))))
    else $error("lock write value");
  lock_rise_a: assert property ((o_lock_bits & ~$past(o_lock_bits)) != 8'h00 |-> ers_q)
    else $error("lock bit unprogrammed without erase");
  fuse_read_a: assert property (!i_pins.out_enable_n && cmd_q == CMD_RD_FUSE &&
    i_pins.byte_select == BSEL_11 |=> o_data == $past(o_fuse_hi)) else $error("fuse high read");
  calib_read_a: assert property (
    !i_pins.out_enable_n && cmd_q == CMD_RD_SIG && adr_q == 8'h00 && i_pins.byte_select[0]
    |=> o_data == IDENT.calib) else $error("calibration read");

  cover property (wr_go && cmd_q == CMD_ERASE);
  cover property (wr_go && cmd_q == CMD_WR_LOCK && o_lock_bits[1:0] == 2'h0);
  cover property ($rose(o_data_oe) && cmd_q == CMD_RD_EEPROM);
endmodule

bind nvm_prog_port nvm_prog_port_assertions #(.WRITE_LEN(WRITE_LEN), .ERASE_LEN(ERASE_LEN),
  .IDENT(IDENT)) u_chk (.i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .i_pins(i_pins),
  .o_data(o_data), .o_data_oe(o_data_oe), .o_ready_busy_flag(o_ready_busy_flag),
  .o_fuse_lo(o_fuse_lo), .o_fuse_hi(o_fuse_hi), .o_fuse_ext(o_fuse_ext),
  .o_lock_bits(o_lock_bits));

/* test/tb.sv */
// Testbench: programmer model plays call sequences against the port.
// Assumes short busy lengths so a run stays small.
`timescale 1ns/100ps
module tb;
  import nvm_prog_pkg::*;
  localparam logic [TIMER_W-1:0] WLEN = 24'h000064;
  localparam logic [TIMER_W-1:0] ELEN = 24'h0000c8;
  localparam ident_t ID = '{8'ha5, 8'h3c, 8'h96, 8'h4b}; // Arbitrary
  logic       clk = 1'b0;
  logic       rst_b = 1'b0;
  prog_pins_t pins;
  logic [7:0] data, f_lo, f_hi, f_ext, lock, v;
  logic       oe, rdy, o;
  int         error_cnt = 0;
  int         checked = 0;
  logic [7:0] fv [3] = '{8'hd9, 8'hfe, 8'h62};
  logic [1:0] fb [3] = '{BSEL_01, BSEL_10, BSEL_00};
  logic [7:0] sg [3] = '{ID.sig0, ID.sig1, ID.sig2};

  always #2 clk = ~clk;

  nvm_prog_port #(.WRITE_LEN(WLEN), .ERASE_LEN(ELEN), .IDENT(ID)) DUT (.i_core_clk(clk),
    .i_rst_b(rst_b), .i_pins(pins), .o_data(data), .o_data_oe(oe), .o_ready_busy_flag(rdy),
    .o_fuse_lo(f_lo), .o_fuse_hi(f_hi), .o_fuse_ext(f_ext), .o_lock_bits(lock));
  nvm_programmer prog (.i_core_clk(clk), .i_data(data), .i_data_oe(oe), .o_pins(pins));

  ////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    $display("checked=%0d error_cnt=%0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // Write pulse, then a bounded wait for the flag to come back
  task automatic wr(input logic [1:0] bs);
    prog.write(bs);
    check({7'h00, rdy}, 8'h00);
    for (int n = 0; n < 1000 && rdy !== 1'b1; n++) @(negedge clk);
    check({7'h00, rdy}, 8'h01);
  endtask

  task automatic rd(input logic [1:0] bs, input logic [7:0] exp);
    prog.read(bs, v, o);
    check(v, exp);
    check({7'h00, o}, 8'h01);
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(negedge clk);
    rst_b = 1'b1;
    @(negedge clk);
    check(lock, 8'hff);
    prog.load(LOAD_CMD, BSEL_00, CMD_ERASE);
    wr(BSEL_00);
    // EEPROM page: high byte once, then low address, data, latch
    prog.load(LOAD_CMD, BSEL_00, CMD_WR_EEPROM);
    prog.load(LOAD_ADDR, BSEL_01, 8'h00);
    for (int i = 0; i < 8; i++) begin
      prog.load(LOAD_ADDR, BSEL_00, 8'(i));
      prog.load(LOAD_DATA, BSEL_00, 8'hc0 ^ 8'(i));
      prog.latch();
    end
    wr(BSEL_00);
    prog.load(LOAD_CMD, BSEL_00, CMD_NOP);
    prog.write(BSEL_00);
    check({7'h00, rdy}, 8'h01);
    prog.load(LOAD_CMD, BSEL_00, CMD_RD_EEPROM);
    for (int i = 0; i < 8; i++) begin
      prog.load(LOAD_ADDR, BSEL_00, 8'(i));
      rd(BSEL_00, 8'hc0 ^ 8'(i));
    end
    // One flash word with distinct halves so the byte select is visible
    prog.load(LOAD_CMD, BSEL_00, CMD_WR_FLASH);
    prog.load(LOAD_ADDR, BSEL_01, 8'h01);
    prog.load(LOAD_ADDR, BSEL_00, 8'h05);
    prog.load(LOAD_DATA, BSEL_00, 8'h12);
    prog.load(LOAD_DATA, BSEL_01, 8'h34);
    prog.latch();
    wr(BSEL_00);
    prog.load(LOAD_CMD, BSEL_00, CMD_NOP);
    prog.load(LOAD_CMD, BSEL_00, CMD_RD_FLASH);
    prog.load(LOAD_ADDR, BSEL_10, 8'h00);
    prog.load(LOAD_ADDR, BSEL_01, 8'h01);
    prog.load(LOAD_ADDR, BSEL_00, 8'h05);
    rd(BSEL_00, 8'h12);
    rd(BSEL_01, 8'h34);
    // Each fuse byte chosen by selects at the write strobe
    prog.load(LOAD_CMD, BSEL_00, CMD_WR_FUSE);
    for (int k = 0; k < 3; k++) begin
      prog.load(LOAD_DATA, BSEL_00, fv[k]);
      wr(fb[k]);
    end
    check(f_hi, fv[0]);
    check(f_ext, fv[1]);
    check(f_lo, fv[2]);
    prog.load(LOAD_CMD, BSEL_00, CMD_RD_FUSE);
    rd(BSEL_11, fv[0]);
    rd(BSEL_10, fv[1]);
    rd(BSEL_00, fv[2]);
    // Lock bits only go down; full lock freezes the boot bits
    prog.load(LOAD_CMD, BSEL_00, CMD_WR_LOCK);
    prog.load(LOAD_DATA, BSEL_00, 8'hfe);
    wr(BSEL_00);
    check(lock, 8'hfe);
    prog.load(LOAD_DATA, BSEL_00, 8'hff);
    wr(BSEL_00);
    check(lock, 8'hfe);
    prog.load(LOAD_DATA, BSEL_00, 8'hfc);
    wr(BSEL_00);
    prog.load(LOAD_DATA, BSEL_00, 8'h00);
    wr(BSEL_00);
    check(lock, 8'h3c);
    prog.load(LOAD_CMD, BSEL_00, CMD_RD_FUSE);
    rd(BSEL_01, 8'h3c);
    prog.load(LOAD_CMD, BSEL_00, CMD_RD_SIG);
    for (int i = 0; i < 3; i++) begin
      prog.load(LOAD_ADDR, BSEL_00, 8'(i));
      rd(BSEL_00, sg[i]);
    end
    prog.load(LOAD_ADDR, BSEL_00, 8'h00);
    rd(BSEL_01, ID.calib);
    prog.load(LOAD_CMD, BSEL_00, CMD_NOP);
    prog.read(BSEL_00, v, o);
    check({7'h00, o}, 8'h00);
    prog.load(LOAD_CMD, BSEL_00, CMD_ERASE);
    wr(BSEL_00);
    check(lock, 8'hff);
    check(f_hi, fv[0]);
    finish_test();
  end

  // Watchdog about three and a half times the expected run of some 42 us
  initial begin
    #150000;
    error_cnt++;
    finish_test();
  end
endmodule
